// ### src/imcl_pkg.sv
// Package with register map, field layout and encodings of the low-source mode control block.
package imcl_pkg;
    localparam int NUM_SRC = 4;
    localparam logic [31:0] SOURCE_MODE_REG_0_ADDR = 32'hffffe000;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hffffe100;
    localparam logic [31:0] IRQ_ENABLE_ADDR = 32'hffffe104;
    localparam logic [31:0] IRQ_CLEAR_ADDR = 32'hffffe108;
    localparam logic [31:0] PENDING_ADDR = 32'hffffe10c;
    localparam int BYTE_W = 8;
    localparam int SENSE_LSB = 4;
    localparam int DMA_BIT = 3;
    localparam int LEVEL_LSB = 0;
    localparam logic [7:0] BYTE_MASK = 8'h3f;
    localparam logic [31:0] MODE_RESET = 32'h00000000;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_HIGH = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } imcl_sense_t;
endpackage

// ### src/imcl_mode_ctrl.sv
// Mode control, detection, arbitration and DMA routing for interrupt sources 0 to 3.
//
// What this block does
// - Sensitivity 00 low level, 01 high level, 10 falling, 11 rising edge.
// - DMA-trigger bit 0 means interrupt only, 1 routes events to DMA.
// - Without DMA trigger, 3-bit field is priority; 000 masks the source.
// - With DMA trigger, 3-bit field selects the DMA channel number.
// - One byte per source: sense 5:4, DMA bit 3, field 2:0.
// - All mode fields reset to zero.
// - Level 7 is highest; highest pending level goes to the core.
// - Equal highest levels deliver the lowest source number as vector.
`timescale 1ns/100ps
module imcl_mode_ctrl #(
    parameter int NSRC = imcl_pkg::NUM_SRC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [NSRC-1:0] req_in,
    input wire logic [NSRC-1:0] src_ack,
    output logic [2:0] irq_level,
    output logic [5:0] irq_vector,
    output logic irq_valid,
    output logic [7:0] dma_trigger,
    output logic irq
);
    import imcl_pkg::*;

    logic [31:0] mode;
    logic [NSRC-1:0] s1, s2, s3;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] pin_q;
    logic [NSRC-1:0] irq_req;
    logic [NSRC-1:0] det;
    logic [NSRC-1:0] ev_stat, ev_en;
    logic [NSRC-1:0] edge_ev;
    logic [2:0] next_level;
    logic [5:0] next_vector;
    logic [7:0] next_dma;

    // Pins come from outside the clock; three stages, change taken when stages two and three agree.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= req_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // The agreed pin value moves only when stages two and three match.
    // A single unsettled sample therefore never makes a level or an edge on its own.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= '0;
        end else begin
            pin_q <= (s2 & s3) | (pin_q & (s2 ^ s3));
        end
    end

    // Per-source decode of the mode byte into a detected event or level.
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : gen_src
            logic [1:0] sense;
            logic hit;
            assign sense = mode[g*BYTE_W+SENSE_LSB +: 2];
            // Edges compare the newly agreed value against the last agreed one.
            always_comb begin
                case (imcl_sense_t'(sense))
                    SENSE_LOW: hit = ~pin_q[g];
                    SENSE_HIGH: hit = pin_q[g];
                    SENSE_FALL: hit = pin_q[g] & ~s2[g] & ~s3[g];
                    SENSE_RISE: hit = ~pin_q[g] & s2[g] & s3[g];
                    default: hit = 1'b0;
                endcase
            end
            assign det[g] = hit;
            assign edge_ev[g] = sense[1] & hit;
        end
    endgenerate

    // Edge events latch until acknowledged; level sources follow the pin directly.
    // A new edge in the acknowledge cycle wins so it is never lost.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend <= '0;
        end else begin
            for (int i = 0; i < NSRC; i++) begin
                if (mode[i*BYTE_W+SENSE_LSB+1]) begin
                    pend[i] <= edge_ev[i] | (pend[i] & ~src_ack[i]);
                end else begin
                    pend[i] <= det[i];
                end
            end
        end
    end

    // Arbitration over interrupt-mode sources; DMA sources instead hold their channel trigger for as long as they pend.
    always_comb begin
        next_level = 3'h0;
        next_vector = 6'h00;
        next_dma = 8'h00;
        irq_req = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pend[i] && mode[i*BYTE_W+DMA_BIT]) begin
                next_dma[mode[i*BYTE_W+LEVEL_LSB +: 3]] = 1'b1;
            end else if (pend[i] && mode[i*BYTE_W+LEVEL_LSB +: 3] != 3'h0) begin
                irq_req[i] = 1'b1;
                // Descending scan with >= lets the lower number win a tie.
                if (mode[i*BYTE_W+LEVEL_LSB +: 3] >= next_level) begin
                    next_level = mode[i*BYTE_W+LEVEL_LSB +: 3];
                    next_vector = 6'(i);
                end
            end
        end
    end

    // Arbitration results are registered so the core sees glitch-free values.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_level <= 3'h0;
            irq_vector <= 6'h00;
            irq_valid <= 1'b0;
            dma_trigger <= 8'h00;
        end else begin
            irq_level <= next_level;
            irq_vector <= next_vector;
            irq_valid <= (next_level != 3'h0);
            dma_trigger <= next_dma;
        end
    end

    // Mode register write; unused top bits of each byte are dropped.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= MODE_RESET;
        end else if (wr && addr == SOURCE_MODE_REG_0_ADDR) begin
            mode <= wdata & {4{BYTE_MASK}};
        end
    end

    // Sticky status per source, set by unmasked interrupt requests; set beats clear.
    // Masked and DMA sources stay out of it, so a level-0 source never raises the line.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ev_stat <= IRQ_RESET;
        end else begin
            ev_stat <= irq_req | (ev_stat & ~((wr && addr == IRQ_CLEAR_ADDR) ?
                wdata[NSRC-1:0] : '0));
        end
    end

    // Enable register gating the status onto the level interrupt line.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ev_en <= IRQ_RESET;
        end else if (wr && addr == IRQ_ENABLE_ADDR) begin
            ev_en <= wdata[NSRC-1:0];
        end
    end

    assign irq = |(ev_stat & ev_en);

    // Read data stand in the cycle after the strobe only; unmapped reads give zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                SOURCE_MODE_REG_0_ADDR: rdata <= mode;
                IRQ_STATUS_ADDR: rdata <= 32'(ev_stat);
                IRQ_ENABLE_ADDR: rdata <= 32'(ev_en);
                PENDING_ADDR: rdata <= {20'h00000, irq_valid, irq_level, 2'h0, irq_vector};
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // Mode bits survive unchanged when the write has them; top bits never set.
    a_mode_unused_zero: assert property (@(posedge clk) disable iff (!rstn)
        (mode & ~{4{BYTE_MASK}}) == 32'h0)
        else $error("unused mode bits set");
    a_mode_write: assert property (@(posedge clk) disable iff (!rstn)
        wr && addr == SOURCE_MODE_REG_0_ADDR |=> mode == ($past(wdata) & {4{BYTE_MASK}}))
        else $error("mode write not stored");
    a_level_prio: assert property (@(posedge clk) disable iff (!rstn)
        next_level != 3'h0 |=> irq_valid &&
        irq_level == $past(mode[next_vector[1:0]*BYTE_W+LEVEL_LSB +: 3]))
        else $error("level does not match winner");
    a_tie_lowest: assert property (@(posedge clk) disable iff (!rstn)
        irq_valid && irq_vector != 6'h0 |-> !$past(pend[0] && !mode[DMA_BIT] &&
        mode[LEVEL_LSB +: 3] != 3'h0 && mode[LEVEL_LSB +: 3] >= next_level))
        else $error("lower source lost a tie");
    a_masked_quiet: assert property (@(posedge clk) disable iff (!rstn)
        mode == 32'h0 |=> !irq_valid)
        else $error("masked source raised a level");
    a_dma_no_irq: assert property (@(posedge clk) disable iff (!rstn)
        next_level != 3'h0 |=> !$past(mode[next_vector[1:0]*BYTE_W+DMA_BIT]))
        else $error("dma source reported as interrupt");
    a_dma_route: assert property (@(posedge clk) disable iff (!rstn)
        pend[2] && mode[2*BYTE_W+DMA_BIT] |=>
        dma_trigger[$past(mode[2*BYTE_W+LEVEL_LSB +: 3])])
        else $error("dma trigger missing");
    a_high_sense: assert property (@(posedge clk) disable iff (!rstn)
        mode[BYTE_W+SENSE_LSB +: 2] == 2'b01 && pin_q[1] |=> pend[1])
        else $error("high level not detected");
    a_status_sticky: assert property (@(posedge clk) disable iff (!rstn)
        ev_stat[0] && !(wr && addr == IRQ_CLEAR_ADDR) |=> ev_stat[0])
        else $error("status bit lost without a clear");
    a_read_once: assert property (@(posedge clk) disable iff (!rstn)
        !rd |=> rdata == 32'h0)
        else $error("read data outside its cycle");
    c_irq_seen: cover property (@(posedge clk) disable iff (!rstn) irq_valid && irq_level == 3'h7);
    c_dma_seen: cover property (@(posedge clk) disable iff (!rstn) dma_trigger != 8'h0);
    c_irq_out: cover property (@(posedge clk) disable iff (!rstn) irq);
    c_edge_seen: cover property (@(posedge clk) disable iff (!rstn) |edge_ev);
    c_ack_seen: cover property (@(posedge clk) disable iff (!rstn) |(pend & src_ack));
endmodule

// ### testbench/imcl_far_model.sv
// Request pins and core or DMA acknowledge model for the mode control block.
`timescale 1ns/100ps
module imcl_far_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] pins,
    input wire logic ack_en,
    input wire logic irq_valid,
    input wire logic [5:0] irq_vector,
    input wire logic dma_any,
    output logic [3:0] req_in,
    output logic [3:0] src_ack
);
    // Pins follow the bench; source 0 idles high so its low-level sense stays quiet.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_in <= 4'h1;
            src_ack <= 4'h0;
        end else begin
            req_in <= pins;
            // One-cycle acknowledge; a DMA take clears every latched edge at once.
            if (ack_en && src_ack == 4'h0 && dma_any) begin
                src_ack <= 4'hf;
            end else if (ack_en && src_ack == 4'h0 && irq_valid) begin
                src_ack <= 4'h1 << irq_vector[1:0];
            end else begin
                src_ack <= 4'h0;
            end
        end
    end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the low-source mode control block.
`timescale 1ns/100ps
module tb_top;
    import imcl_pkg::*;
    logic clk, rstn, wr, rd, ack_en;
    logic [31:0] addr, wdata, rdata, s, m;
    logic [3:0] pins, req_in, src_ack;
    logic [2:0] irq_level;
    logic [5:0] irq_vector;
    logic [7:0] dma_trigger;
    logic irq_valid, irq;
    int mismatches, cmp_count;
    imcl_mode_ctrl u_imcl_mode_ctrl (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .req_in(req_in), .src_ack(src_ack),
        .irq_level(irq_level), .irq_vector(irq_vector), .irq_valid(irq_valid),
        .dma_trigger(dma_trigger), .irq(irq));
    imcl_far_model u_imcl_far_model (.clk(clk), .rstn(rstn), .pins(pins), .ack_en(ack_en),
        .irq_valid(irq_valid), .irq_vector(irq_vector), .dma_any(|dma_trigger),
        .req_in(req_in), .src_ack(src_ack));
    // Free-running 125 MHz clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Winner among level sources: strict compare keeps the lowest number on a tie.
    function automatic logic [8:0] exp_win(logic [31:0] md, logic [3:0] p);
        logic [2:0] best;
        logic [5:0] v;
        logic [7:0] b;
        best = 3'h0;
        v = 6'h0;
        for (int i = 0; i < 4; i++) begin
            b = md[8*i +: 8];
            if ((b[4] ? p[i] : !p[i]) && !b[3] && b[2:0] > best) begin
                best = b[2:0];
                v = 6'(i);
            end
        end
        return {best, v};
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (e !== g) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(logic [31:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [31:0] a, logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // Read data stand until the next edge and are taken there.
        @(posedge clk);
        chk("rdata", e, rdata);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch.
    initial begin
        #200000;
        mismatches++;
        print_verdict();
    end
    initial begin
        {wr, rd, ack_en, addr, wdata, mismatches, cmp_count} = '0;
        pins = 4'h1;
        s = 32'd98186;
        rstn = 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(SOURCE_MODE_REG_0_ADDR, MODE_RESET);
        rd_reg(32'hffffe0f0, 32'h0);
        // Random layouts, then random level priorities against random pins.
        for (int k = 0; k < 12; k++) begin
            s = lfsr(s);
            wr_reg(SOURCE_MODE_REG_0_ADDR, s & ~32'h30);
            rd_reg(SOURCE_MODE_REG_0_ADDR, s & 32'h3f3f3f0f);
            m = lfsr(s) & 32'h17171707;
            pins <= s[3:0];
            wr_reg(SOURCE_MODE_REG_0_ADDR, m);
            repeat (10) @(posedge clk);
            chk("win", {23'h0, exp_win(m, s[3:0])}, {23'h0, irq_level, irq_vector});
            chk("valid", 32'(exp_win(m, s[3:0]) > 9'h3f), 32'(irq_valid));
        end
        // Status, enable and clear around a low-level source 0 at level 7.
        pins <= 4'h0;
        wr_reg(SOURCE_MODE_REG_0_ADDR, 32'h07);
        // Status is sticky, so drop what the random phase left behind.
        wr_reg(IRQ_CLEAR_ADDR, 32'hf);
        wr_reg(IRQ_ENABLE_ADDR, 32'h1);
        repeat (10) @(posedge clk);
        chk("irq", 1, 32'(irq));
        wr_reg(IRQ_ENABLE_ADDR, 32'h0);
        @(posedge clk);
        chk("irq_masked", 0, 32'(irq));
        pins <= 4'h1;
        repeat (10) @(posedge clk);
        rd_reg(IRQ_STATUS_ADDR, 32'h1);
        wr_reg(IRQ_CLEAR_ADDR, 32'hf);
        rd_reg(IRQ_STATUS_ADDR, 32'h0);
        // Falling edge at level 3 on source 1, rising DMA edge to channel 5 on source 2.
        pins <= 4'h3;
        wr_reg(SOURCE_MODE_REG_0_ADDR, 32'h003d2300);
        repeat (10) @(posedge clk);
        // A mode change can leave a stale latched edge; acknowledge it before real edges.
        ack_en <= 1'b1;
        repeat (6) @(posedge clk);
        ack_en <= 1'b0;
        repeat (4) @(posedge clk);
        chk("quiet", 32'h0, {dma_trigger, irq_level, irq_valid});
        pins <= 4'h5;
        repeat (10) @(posedge clk);
        chk("dma", 32'h20, 32'(dma_trigger));
        chk("edge", 32'h0c1, {23'h0, irq_level, irq_vector});
        ack_en <= 1'b1;
        repeat (10) @(posedge clk);
        chk("acked", 32'h0, {dma_trigger, irq_level, irq_valid});
        print_verdict();
    end
endmodule
